// >>> design/flash_ctrl_defines.svh
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH
// Overview of operation
// - target answers at seven-bit address 0x30, write byte 0x60.
// - all four registers hold 0x00 after reset.
// - enable low or supply-low lockout returns every register to default.
// - write stores data byte into register named by the subaddress byte; subaddress 3 (flags) ignores writes.
// - read returns the register last selected by the subaddress.
// - bit 0 is least significant, bit 7 most significant.
// - indicator_level zero is off; 1..7 give continuous 2.5 mA steps.
// - power_led_level zero is off; 1..11 is torch, ignoring the trigger.
// - power_led_level 12..31 stays off until pin or soft trigger.
// - power LED current is 35 mA plus 15 mA per code.
// - hardwired 11 flashes; leaving ends it; 0.82 s gives fault.
// - timed mode: trigger rising edge lights flash until timeout.
// - flash duration is 820 ms minus 54.6 ms per timeout_code.
// - held mode: flash follows trigger; overrun sets timeout_fault, disables.
// - writing soft_trigger 1 acts exactly like the trigger pin.
// - overvoltage, overheat, or timeout outside timed mode pull fault_irq_n low, both interfaces.
// - writing 0x00 to led_level_reg clears faults and releases irq.
// - hardwired mode: both mode_ctrl low clears faults, releases irq.
// - overvoltage shuts down, sets bit D0, holds irq until cleared.
// - overheat disables driver, sets bit D2, holds irq until cleared.
// - cathode grounded 820 ms after torch on sets D3 and disables.
// - interface_select high picks hardwired mode, low picks the serial bus.
// - mode_ctrl pair: 00 off, 01 indicator, 10 torch, 11 flash.
`define I2C_ADDR7 7'h30
`define REG_LED_LEVEL 2'h0
`define REG_TIMER_CFG 2'h1
`define REG_SOFT_TRIG 2'h2
`define REG_PROT_FLAGS 2'h3
`define REG_RESET_VAL 8'h00
`define PWR_MSB 7
`define PWR_LSB 3
`define IND_MSB 2
`define IND_LSB 0
`define TMO_MSB 7
`define TMO_LSB 4
`define TIMED_SEL_BIT 0
`define SOFT_TRIG_BIT 0
`define OVERVOLTAGE_FAULT_BIT 0
`define TIMEOUT_FAULT_BIT 1
`define OVERHEAT_FAULT_BIT 2
`define SHORT_FAULT_BIT 3
`define TORCH_MAX_CODE 5'h0b
`define FLASH_MIN_CODE 5'h0c
`define MODE_OFF 2'h0
`define MODE_IND 2'h1
`define MODE_TORCH 2'h2
`define MODE_FLASH 2'h3
`define LED_BASE_MA 10'h023
`define LED_STEP_MA 10'h00f
`define IND_STEP_HALF_MA 6'h05
`define CLK_PERIOD_NS 5
`define FLASH_MAX_US 820000
`define FLASH_STEP_US 54600
`define SHORT_WAIT_US 820000
`endif

// >>> design/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_SUB, I2C_SUB_ACK,
    I2C_WDATA, I2C_WDATA_ACK, I2C_RDATA, I2C_RDATA_ACK
  } i2c_state_t;
endpackage

// >>> design/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] stage1;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      stage1 <= '0;
      o_sync <= '0;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // sync_2ff

// >>> design/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 28
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [W-1:0] i_limit,
  output logic o_expired
);
  logic [W-1:0] count;
  // restarts from zero whenever run drops; expiry holds until then
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || !i_run)
    begin
      count <= '0;
      o_expired <= 1'b0;
    end
    else if (count >= i_limit - W'(1))
      o_expired <= 1'b1;
    else
      count <= count + W'(1);
  end
endmodule // cycle_timer

// >>> design/flash_led_control_and_faults.sv
`timescale 1ns/1ps
`include "flash_ctrl_defines.svh"
module flash_led_control_and_faults #(
  parameter int TW = 28,
  parameter int unsigned FLASH_MAX_CYCLES = `FLASH_MAX_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned FLASH_STEP_CYCLES = `FLASH_STEP_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned SHORT_WAIT_CYCLES = `SHORT_WAIT_US * 1000 / `CLK_PERIOD_NS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_supply_low_lockout,
  input wire logic i_interface_select,
  input wire logic i_mode_ctrl_hi,
  input wire logic i_mode_ctrl_lo,
  input wire logic i_flash_trigger_pin,
  input wire logic i_overvoltage_trip,
  input wire logic i_overheat_trip,
  input wire logic i_cathode_grounded,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_fault_irq_n_out,
  output logic o_fault_irq_n_oe,
  output logic o_indicator_on,
  output logic [5:0] o_indicator_half_ma,
  output logic o_power_led_on,
  output logic o_torch_active,
  output logic o_flash_active,
  output logic [9:0] o_power_led_ma,
  output logic [3:0] o_fault_flags
);
  logic [9:0] pins_s;
  logic enable_s, lockout_s, interface_select_s, trig_s, ov_s, ot_s, gnd_s, scl_s, sda_s;
  logic [1:0] mode_s;
  logic scl_q, sda_q;
  logic soft_rst, regs_rst, hw_mode;
  flash_ctrl_pkg::i2c_state_t i2c_state;
  logic [7:0] shreg, txreg, rd_word;
  logic [3:0] bitcnt;
  logic [1:0] sub;
  logic rw, nack, wr_pulse;
  logic [7:0] wr_data;
  logic [7:0] led_level_reg, timer_cfg_reg, soft_trig_reg;
  logic [3:0] faults, next_faults;
  logic start_cond, stop_cond, scl_rise, scl_fall;
  logic [4:0] pwr_code;
  logic [2:0] ind_code;
  logic timed_sel, trig, trig_q, flash_level, torch_level, disabled;
  logic flash_on, torch_on, flash_exp, short_exp, fault_clear;
  logic [TW-1:0] flash_limit;

  function automatic logic [7:0] reg_read(input logic [1:0] a, input logic [3:0] f);
    unique case (a)
      `REG_LED_LEVEL: reg_read = led_level_reg;
      `REG_TIMER_CFG: reg_read = timer_cfg_reg;
      `REG_SOFT_TRIG: reg_read = soft_trig_reg;
      `REG_PROT_FLAGS: reg_read = {4'h0, f};
    endcase
  endfunction
  assign rd_word = reg_read(sub, faults);

  // every pin from outside except the clock and i_rst_n passes two flops first
  sync_2ff #(.W(10)) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_enable, i_supply_low_lockout, i_interface_select, i_mode_ctrl_hi,
      i_mode_ctrl_lo, i_flash_trigger_pin, i_overvoltage_trip, i_overheat_trip,
      i_cathode_grounded, i_scl}),
    .o_sync(pins_s)
  );
  sync_2ff #(.W(1)) u_sda_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_sda),
    .o_sync(sda_s)
  );
  assign {enable_s, lockout_s, interface_select_s, mode_s, trig_s, ov_s, ot_s, gnd_s, scl_s} = pins_s;

  assign soft_rst = !enable_s || lockout_s;
  assign regs_rst = !i_rst_n || soft_rst;
  assign hw_mode = interface_select_s;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  assign start_cond = scl_s && scl_q && sda_q && !sda_s;
  assign stop_cond = scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;

  // serial target; ignored while the hardwired interface is chosen
  always_ff @(posedge i_sys_clk)
  begin
    wr_pulse <= 1'b0;
    if (regs_rst || hw_mode || stop_cond)
    begin
      i2c_state <= flash_ctrl_pkg::I2C_IDLE;
      o_sda_oe <= 1'b0;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      wr_pulse <= 1'b0;
      wr_data <= 8'h00;
      if (regs_rst)
        sub <= 2'h0;
    end
    else if (start_cond)
    begin
      i2c_state <= flash_ctrl_pkg::I2C_ADDR;
      o_sda_oe <= 1'b0;
      bitcnt <= 4'h0;
    end
    else if (scl_rise)
    begin
      if (i2c_state == flash_ctrl_pkg::I2C_RDATA_ACK)
        nack <= sda_s;
      else
      begin
        shreg <= {shreg[6:0], sda_s};
        bitcnt <= bitcnt + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (i2c_state)
        flash_ctrl_pkg::I2C_IDLE: ;
        flash_ctrl_pkg::I2C_ADDR:
          if (bitcnt == 4'h8)
          begin
            if (shreg[7:1] == `I2C_ADDR7)
            begin
              rw <= shreg[0];
              o_sda_oe <= 1'b1;
              i2c_state <= flash_ctrl_pkg::I2C_ADDR_ACK;
            end
            else
              i2c_state <= flash_ctrl_pkg::I2C_IDLE;
          end
        flash_ctrl_pkg::I2C_ADDR_ACK:
        begin
          bitcnt <= 4'h0;
          if (rw)
          begin
            txreg <= rd_word;
            o_sda_oe <= !rd_word[7];
            i2c_state <= flash_ctrl_pkg::I2C_RDATA;
          end
          else
          begin
            o_sda_oe <= 1'b0;
            i2c_state <= flash_ctrl_pkg::I2C_SUB;
          end
        end
        flash_ctrl_pkg::I2C_SUB:
          if (bitcnt == 4'h8)
          begin
            sub <= shreg[1:0];
            o_sda_oe <= 1'b1;
            i2c_state <= flash_ctrl_pkg::I2C_SUB_ACK;
          end
        flash_ctrl_pkg::I2C_SUB_ACK, flash_ctrl_pkg::I2C_WDATA_ACK:
        begin
          o_sda_oe <= 1'b0;
          bitcnt <= 4'h0;
          i2c_state <= flash_ctrl_pkg::I2C_WDATA;
        end
        flash_ctrl_pkg::I2C_WDATA:
          if (bitcnt == 4'h8)
          begin
            wr_data <= shreg;
            wr_pulse <= 1'b1;
            o_sda_oe <= 1'b1;
            i2c_state <= flash_ctrl_pkg::I2C_WDATA_ACK;
          end
        flash_ctrl_pkg::I2C_RDATA:
          if (bitcnt == 4'h8)
          begin
            o_sda_oe <= 1'b0;
            i2c_state <= flash_ctrl_pkg::I2C_RDATA_ACK;
          end
          else
          begin
            txreg <= {txreg[6:0], 1'b0};
            o_sda_oe <= !txreg[6];
          end
        flash_ctrl_pkg::I2C_RDATA_ACK:
          if (nack)
            i2c_state <= flash_ctrl_pkg::I2C_IDLE;
          else
          begin
            bitcnt <= 4'h0;
            txreg <= rd_word;
            o_sda_oe <= !rd_word[7];
            i2c_state <= flash_ctrl_pkg::I2C_RDATA;
          end
      endcase
    end
  end
  assign o_sda_out = 1'b0;

  // control registers
  always_ff @(posedge i_sys_clk)
  begin
    if (regs_rst)
    begin
      led_level_reg <= `REG_RESET_VAL;
      timer_cfg_reg <= `REG_RESET_VAL;
      soft_trig_reg <= `REG_RESET_VAL;
    end
    else if (wr_pulse)
    begin
      unique case (sub)
        `REG_LED_LEVEL: led_level_reg <= wr_data;
        `REG_TIMER_CFG: timer_cfg_reg <= wr_data;
        `REG_SOFT_TRIG: soft_trig_reg <= wr_data;
        `REG_PROT_FLAGS: ;
      endcase
    end
  end

  assign pwr_code = led_level_reg[`PWR_MSB:`PWR_LSB];
  assign ind_code = led_level_reg[`IND_MSB:`IND_LSB];
  assign timed_sel = timer_cfg_reg[`TIMED_SEL_BIT];
  assign trig = trig_s || soft_trig_reg[`SOFT_TRIG_BIT];
  assign flash_level = pwr_code >= `FLASH_MIN_CODE;
  assign torch_level = pwr_code != 5'h00 && pwr_code <= `TORCH_MAX_CODE;
  assign disabled = |faults;
  // hardwired mode keeps the fixed longest window
  assign flash_limit = hw_mode ? TW'(FLASH_MAX_CYCLES) :
    TW'(FLASH_MAX_CYCLES - FLASH_STEP_CYCLES * 32'(timer_cfg_reg[`TMO_MSB:`TMO_LSB]));

  always_ff @(posedge i_sys_clk)
  begin
    if (regs_rst)
      trig_q <= 1'b0;
    else
      trig_q <= trig;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (regs_rst || disabled)
      flash_on <= 1'b0;
    else if (hw_mode)
      flash_on <= mode_s == `MODE_FLASH && !flash_exp;
    else if (timed_sel)
    begin
      if (trig && !trig_q && flash_level)
        flash_on <= 1'b1;
      else if (flash_exp || !flash_level)
        flash_on <= 1'b0;
    end
    else
      flash_on <= trig && flash_level && !flash_exp;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (regs_rst || disabled)
      torch_on <= 1'b0;
    else if (hw_mode)
      torch_on <= mode_s == `MODE_TORCH;
    else
      torch_on <= torch_level;
  end

  cycle_timer #(.W(TW)) u_flash_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(!regs_rst),
    .i_run(flash_on),
    .i_limit(flash_limit),
    .o_expired(flash_exp)
  );
  cycle_timer #(.W(TW)) u_short_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(!regs_rst),
    .i_run(torch_on),
    .i_limit(TW'(SHORT_WAIT_CYCLES)),
    .o_expired(short_exp)
  );

  // a change between torch levels leaves torch_on high, so the short timer keeps counting
  assign fault_clear = hw_mode ? mode_s == `MODE_OFF :
    wr_pulse && sub == `REG_LED_LEVEL && wr_data == 8'h00;

  always_comb
  begin
    next_faults = fault_clear ? 4'h0 : faults;
    // a new event wins over a clear in the same cycle
    if (ov_s)
      next_faults[`OVERVOLTAGE_FAULT_BIT] = 1'b1;
    if (flash_exp && flash_on && (hw_mode || !timed_sel))
      next_faults[`TIMEOUT_FAULT_BIT] = 1'b1;
    if (ot_s)
      next_faults[`OVERHEAT_FAULT_BIT] = 1'b1;
    if (short_exp && torch_on && gnd_s)
      next_faults[`SHORT_FAULT_BIT] = 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (regs_rst)
      faults <= 4'h0;
    else
      faults <= next_faults;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (regs_rst)
      o_fault_irq_n_oe <= 1'b0;
    else
      o_fault_irq_n_oe <= |next_faults;
  end
  assign o_fault_irq_n_out = 1'b0;

  always_ff @(posedge i_sys_clk)
  begin
    if (regs_rst)
    begin
      o_indicator_on <= 1'b0;
      o_indicator_half_ma <= 6'h00;
      o_power_led_ma <= 10'h000;
    end
    else
    begin
      o_indicator_on <= !disabled && (hw_mode ? mode_s == `MODE_IND : ind_code != 3'h0);
      o_indicator_half_ma <= 6'(ind_code) * `IND_STEP_HALF_MA;
      o_power_led_ma <= pwr_code == 5'h00 ? 10'h000 :
        `LED_BASE_MA + 10'(pwr_code) * `LED_STEP_MA;
    end
  end

  assign o_torch_active = torch_on;
  assign o_flash_active = flash_on;
  assign o_power_led_on = torch_on || flash_on;
  assign o_fault_flags = faults;
endmodule // flash_led_control_and_faults

// >>> testbench/flash_monitor.sv
`timescale 1ns/1ps
module flash_monitor #(
  parameter int unsigned FLASH_MAX_CYCLES = 200
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_supply_low_lockout,
  input wire logic i_overvoltage_trip,
  input wire logic i_overheat_trip,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_fault_irq_n_out,
  input wire logic o_fault_irq_n_oe,
  input wire logic o_indicator_on,
  input wire logic [5:0] o_indicator_half_ma,
  input wire logic o_power_led_on,
  input wire logic o_torch_active,
  input wire logic o_flash_active,
  input wire logic [9:0] o_power_led_ma,
  input wire logic [3:0] o_fault_flags
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [15:0] on_cnt;
  // run length of one flash; slack of 2 for sync lag
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || !o_flash_active)
      on_cnt <= 16'h0000;
    else
      on_cnt <= on_cnt + 16'h0001;
  end
  chk_flash_len_cap:
  assert property (on_cnt <= FLASH_MAX_CYCLES + 2)
    else $error("flash stayed on past the watchdog");
  chk_irq_tracks_flags:
  assert property (o_fault_irq_n_oe == |o_fault_flags)
    else $error("irq pin not following fault flags");
  chk_open_drain_low:
  assert property (o_sda_out == 1'b0 && o_fault_irq_n_out == 1'b0)
    else $error("open-drain data not low");
  chk_fault_kills_out:
  assert property (|o_fault_flags |=> !o_torch_active && !o_flash_active && !o_indicator_on)
    else $error("outputs on during fault");
  chk_led_on_or:
  assert property (o_power_led_on == (o_torch_active || o_flash_active))
    else $error("power led state mismatch");
  chk_led_ma_law:
  assert property (o_power_led_ma == 10'h000 || (o_power_led_ma >= 10'h032
    && o_power_led_ma <= 10'h1f4 && (o_power_led_ma - 10'h023) % 10'h00f == 10'h000))
    else $error("power led current off the scale");
  chk_ind_law:
  assert property (o_indicator_half_ma <= 6'h23 && o_indicator_half_ma % 6'h05 == 6'h00)
    else $error("indicator current off the scale");
  chk_ov_latch:
  assert property ((i_overvoltage_trip && i_enable && !i_supply_low_lockout) [*6]
    |-> o_fault_flags[0])
    else $error("overvoltage not latched");
  chk_ot_latch:
  assert property ((i_overheat_trip && i_enable && !i_supply_low_lockout) [*6]
    |-> o_fault_flags[2])
    else $error("overheat not latched");
  chk_enable_clear:
  assert property (((!i_enable || i_supply_low_lockout) && !i_overvoltage_trip
    && !i_overheat_trip) [*5] |-> o_fault_flags == 4'h0 && !o_power_led_on)
    else $error("state survives enable low or lockout");
  cover property ($rose(o_flash_active));
  cover property ($rose(o_fault_flags[1]));
  cover property ($rose(o_torch_active));
  cover property ($rose(o_sda_oe));
endmodule // flash_monitor
bind flash_led_control_and_faults flash_monitor #(.FLASH_MAX_CYCLES(FLASH_MAX_CYCLES)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_enable(i_enable),
  .i_supply_low_lockout(i_supply_low_lockout), .i_overvoltage_trip(i_overvoltage_trip),
  .i_overheat_trip(i_overheat_trip), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_fault_irq_n_out(o_fault_irq_n_out), .o_fault_irq_n_oe(o_fault_irq_n_oe),
  .o_indicator_on(o_indicator_on), .o_indicator_half_ma(o_indicator_half_ma),
  .o_power_led_on(o_power_led_on), .o_torch_active(o_torch_active),
  .o_flash_active(o_flash_active), .o_power_led_ma(o_power_led_ma),
  .o_fault_flags(o_fault_flags));

// >>> testbench/i2c_host.sv
`timescale 1ns/1ps
module i2c_host (
  input wire logic i_sys_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // scl idles high between frames
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hw(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // sample mid-high: device answers ~3 cycles after the fall
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    hw(8);
    o_scl = 1'b1;
    hw(4);
    r = i_sda;
    hw(4);
    o_scl = 1'b0;
  endtask
  task automatic start();
    o_sda = 1'b1;
    hw(4);
    o_scl = 1'b1;
    hw(8);
    o_sda = 1'b0;
    hw(8);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda = 1'b0;
    hw(8);
    o_scl = 1'b1;
    hw(8);
    o_sda = 1'b1;
    hw(8);
  endtask
  task automatic xfer(input logic [7:0] w, input logic ack, output logic [7:0] r,
    output logic a);
    for (int i = 7; i >= 0; i--)
      bitx(w[i], r[i]);
    bitx(ack, a);
  endtask
endmodule // i2c_host

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic i_sys_clk, i_rst_n, en, lock, isel, mhi, mlo, trig, ov, ot, cath;
  logic scl, hsda, sda_oe, irq_oe, ind_on, pwr_on, torch, flash;
  logic [5:0] ind_ma;
  logic [9:0] led_ma;
  logic [3:0] flags, c;
  logic [4:0] p;
  logic [2:0] q;
  logic [15:0] flen;
  logic flen_clr;
  logic [4:0] corner [4] = '{5'h00, 5'h0b, 5'h0c, 5'h1f};
  int n_errors = 0;
  int cmp_count = 0;
  // released sda floats high through the pull-up
  wire sda = hsda & ~sda_oe;
  i2c_host u_host (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
  flash_led_control_and_faults #(.FLASH_MAX_CYCLES(200), .FLASH_STEP_CYCLES(10),
    .SHORT_WAIT_CYCLES(100)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_enable(en), .i_supply_low_lockout(lock),
    .i_interface_select(isel), .i_mode_ctrl_hi(mhi), .i_mode_ctrl_lo(mlo),
    .i_flash_trigger_pin(trig), .i_overvoltage_trip(ov), .i_overheat_trip(ot),
    .i_cathode_grounded(cath), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .o_fault_irq_n_out(), .o_fault_irq_n_oe(irq_oe), .o_indicator_on(ind_on),
    .o_indicator_half_ma(ind_ma), .o_power_led_on(pwr_on), .o_torch_active(torch),
    .o_flash_active(flash), .o_power_led_ma(led_ma), .o_fault_flags(flags));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk)
    if (flen_clr)
      flen <= 16'h0000;
    else if (flash === 1'b1)
      flen <= flen + 16'h0001;
  function automatic logic [9:0] ma(logic [4:0] k);
    return (k == 5'h00) ? 10'h000 : 10'h023 + 10'h00f * 10'(k);
  endfunction
  function automatic logic [15:0] tlen(logic [3:0] k);
    return 16'h00c8 - 16'h000a * 16'(k);
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    u_host.start();
    u_host.xfer(8'h60, 1'b1, r, k);
    `CHK(k, 1'b0)
    u_host.xfer(s, 1'b1, r, k);
    u_host.xfer(d, 1'b1, r, k);
    `CHK(k, 1'b0)
    u_host.stop();
  endtask
  task automatic rd(input logic [7:0] s, input logic [7:0] e);
    logic [7:0] r;
    logic k;
    u_host.start();
    u_host.xfer(8'h60, 1'b1, r, k);
    u_host.xfer(s, 1'b1, r, k);
    u_host.start();
    u_host.xfer(8'h61, 1'b1, r, k);
    u_host.xfer(8'hff, 1'b0, r, k);
    `CHK(r, e)
    u_host.xfer(8'hff, 1'b1, r, k);
    u_host.stop();
    `CHK(r, e)
  endtask
  task automatic done(string s);
    $display("test %s finished", s);
  endtask
  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge i_sys_clk);
    n_errors++;
    complete_run;
  end
  initial
  begin
    {i_rst_n, lock, isel, mhi, mlo, trig, ov, ot, cath} = '0;
    en = 1'b1;
    flen_clr = 1'b1;
    void'($urandom(61));
    cyc(10);
    i_rst_n = 1'b1;
    cyc(4);
    `CHK({flags, pwr_on, irq_oe}, 6'h00)
    for (int a = 0; a < 4; a++)
      rd(8'(a), 8'h00);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h00);
    done("reset");
    for (int i = 0; i < 8; i++)
    begin
      p = (i < 4) ? corner[i] : 5'($urandom_range(31));
      q = 3'($urandom_range(7));
      wr(8'h00, 8'h00);
      wr(8'h00, {p, q});
      `CHK(led_ma, ma(p))
      `CHK(ind_ma, 6'(q) * 6'h05)
      `CHK(ind_on, q != 3'h0)
      `CHK(pwr_on, p != 5'h00 && p <= 5'h0b)
      rd(8'h00, {p, q});
    end
    done("levels");
    for (int m = 0; m < 2; m++)
    begin
      c = (m == 0) ? 4'hf : 4'($urandom_range(15));
      wr(8'h01, {c, 4'h1});
      wr(8'h00, 8'ha0);
      flen_clr = 1'b1;
      cyc(1);
      flen_clr = 1'b0;
      if (m == 0)
      begin
        trig = 1'b1;
        cyc(4);
        trig = 1'b0;
      end
      else
        wr(8'h02, 8'h01);
      cyc(250);
      `CHK(flen >= tlen(c) && flen <= tlen(c) + 16'h0002, 1'b1)
      `CHK(flags, 4'h0)
      wr(8'h02, 8'h00);
    end
    wr(8'h01, 8'h00);
    trig = 1'b1;
    cyc(60);
    `CHK(flash, 1'b1)
    trig = 1'b0;
    cyc(6);
    `CHK(flash, 1'b0)
    trig = 1'b1;
    cyc(250);
    `CHK({flags, irq_oe, flash}, 6'h0a)
    trig = 1'b0;
    rd(8'h03, 8'h02);
    wr(8'h00, 8'h00);
    `CHK({flags, irq_oe}, 5'h00)
    done("flash");
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, 8'h28);
      `CHK(pwr_on, 1'b1)
      {ot, ov} = k ? 2'b10 : 2'b01;
      cyc(8);
      `CHK({flags, irq_oe, pwr_on}, k ? 6'h12 : 6'h06)
      {ot, ov} = 2'b00;
      rd(8'h03, k ? 8'h04 : 8'h01);
      wr(8'h00, 8'h00);
      `CHK(irq_oe, 1'b0)
    end
    cath = 1'b1;
    wr(8'h00, 8'h28);
    cyc(120);
    `CHK({flags, torch}, 5'h10)
    cath = 1'b0;
    wr(8'h00, 8'h00);
    for (int j = 0; j < 2; j++)
    begin
      wr(8'h01, 8'h51);
      wr(8'h00, 8'h28);
      `CHK(pwr_on, 1'b1)
      {lock, en} = j ? 2'b11 : 2'b00;
      cyc(6);
      {lock, en} = 2'b01;
      cyc(6);
      rd(8'h01, 8'h00);
      `CHK(pwr_on, 1'b0)
    end
    done("faults");
    isel = 1'b1;
    for (int m = 1; m < 4; m++)
    begin
      {mhi, mlo} = 2'(m);
      cyc(8);
      `CHK(m == 1 ? ind_on : m == 2 ? torch : flash, 1'b1)
    end
    cyc(220);
    `CHK({flags, irq_oe, flash}, 6'h0a)
    {mhi, mlo} = 2'b00;
    cyc(8);
    `CHK({flags, irq_oe}, 5'h00)
    {mhi, mlo} = 2'b11;
    cyc(20);
    `CHK(flash, 1'b1)
    mlo = 1'b0;
    cyc(8);
    `CHK(flash, 1'b0)
    done("hardwired");
    complete_run;
  end
endmodule // tb_top
